// ### shared/gdp_pkg.sv
/*
  Constants shared by the dual GPIO port: register offsets, pin masks,
  control bit positions and reset values.
  Assumes a byte-wide register port with a 3-bit word address.
*/
// Functional notes
// R1 - Direction bit 1 makes a pin an output; 0 makes it an input.
// R2 - An output pin drives the level held in its data latch bit.
// R3 - Data writes always update the latch; input pins do not show it.
// R4 - Normal data read returns the latch for output pins.
// R5 - Normal data read returns the sampled pin level for input pins.
// R6 - Read-modify-write reads return the latch whatever the pin mode; the code returns 0 on 3-pin port pin 2 while it is the reset input.
// R7 - A peripheral asserting its output enable drives the pin instead of the latch.
// R8 - While a peripheral drives, normal reads show the pin; RMW reads the latch.
// R9 - Peripheral input pins use direction 0; normal reads still return pin level.
// R10 - Software disables shared peripheral outputs before plain port use.
// R11 - Reset clears every direction bit of both ports to 0.
// R12 - Float bit 1 in stop or watch mode forces every pin to high impedance.
// R13 - In floated standby each input path is blocked and reads low.
// R14 - Counter clock, serial clock and serial data pins keep input if wake enabled.
// R15 - Float bit 0 in standby leaves pin states and driven levels unchanged.
// R16 - Pull-up select bit 1 connects the pull-up on the 8-pin port.
// R17 - A pin driving low always has its pull-up disconnected.
// R18 - Open-drain pins release to high impedance for latch value 1.
// R19 - 8-pin port bits 7..0 map to pins 7..0; bits 3,2 lack pull-up.
// R20 - 3-pin port has bits 2..0 only and no pull-up register.
// R21 - External reset selection turns pin 2 of the 3-pin port into reset input.
// R22 - Unimplemented bits read as zero and ignore writes.
package gdp_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int P7_W   = 8;
  localparam int PF_W   = 3;

  // ----------------------------------------------------------------
  // Register offsets (word addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_P7_DATA = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_P7_DIR  = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_P7_PU   = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_PF_DATA = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_PF_DIR  = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_CTRL    = 3'h5;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 3'h6;

  // ----------------------------------------------------------------
  // Pin masks and pin numbers of the 8-pin port, plus the 3-pin port reset pin
  // ----------------------------------------------------------------
  localparam logic [P7_W-1:0] P7_PU_MASK   = 8'hF3;
  localparam logic [P7_W-1:0] P7_OD_MASK   = 8'h0C;
  localparam logic [P7_W-1:0] P7_WAKE_MASK = 8'hB0;
  localparam int              P7_CNT_PIN   = 4;
  localparam int              P7_SCK_PIN   = 5;
  localparam int              P7_SDI_PIN   = 7;
  localparam int              PF_RST_PIN   = 2;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_FLOAT    = 0;
  localparam int CTRL_RST_SEL  = 1;
  localparam int CTRL_WAKE_CNT = 2;
  localparam int CTRL_WAKE_SCK = 3;
  localparam int CTRL_WAKE_SDI = 4;
  localparam int CTRL_W        = 5;

  // Status register fields
  localparam int STAT_FLOATED  = 0;
  localparam int STAT_STANDBY  = 1;
  localparam int STAT_RST_PIN  = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [P7_W-1:0]   P7_DIR_RST   = 8'h00;
  localparam logic [P7_W-1:0]   P7_DATA_RST  = 8'h00;
  localparam logic [P7_W-1:0]   P7_PU_RST    = 8'h00;
  localparam logic [PF_W-1:0]   PF_DIR_RST   = 3'h0;
  localparam logic [PF_W-1:0]   PF_DATA_RST  = 3'h0;
  localparam logic [CTRL_W-1:0] CTRL_RST     = 5'h00;
  localparam logic [DATA_W-1:0] RDATA_RST    = 8'h00;

endpackage

// ### hdl/gdp_pin_cell.sv
/*
  One port pin: output select, drive enable, pull-up control and input
  gating, plus the value a data register read returns for this pin.
  Assumes the pad level is synchronous to clk_in.
*/
`timescale 1ns/100ps
module gdp_pin_cell #(
  parameter bit OPEN_DRAIN = 1'b0,
  parameter bit HAS_PULLUP = 1'b1
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Register state
  input  wire logic dir_in,
  input  wire logic latch_in,
  input  wire logic pu_sel_in,
  input  wire logic rmw_in,
  // Peripheral override
  input  wire logic periph_oe_in,
  input  wire logic periph_out_in,
  // Standby and special functions
  input  wire logic float_in,
  input  wire logic wake_en_in,
  input  wire logic port_off_in,
  // Pad
  input  wire logic pad_in,
  output logic      pad_out,
  output logic      pad_oe_out,
  output logic      pullup_out,
  output logic      level_out,
  output logic      rd_val_out
);

  logic drive_en;
  logic drive_val;
  logic in_open;
  logic gated;
  logic next_pad;
  logic next_oe;
  logic next_pu;
  logic next_level;

  always_comb begin
    drive_en  = (dir_in | periph_oe_in) & ~port_off_in;                // [R1] [R7]
    drive_val = periph_oe_in ? periph_out_in : latch_in;               // [R2] [R3] [R7]
    in_open   = ~float_in | wake_en_in;                                // [R14]
    gated     = in_open & ~port_off_in & pad_in;                       // [R13] [R21]
    next_pad  = OPEN_DRAIN ? 1'b0 : drive_val;
    // Float wins over everything; without float the drive just persists
    next_oe   = drive_en & ~float_in & (~OPEN_DRAIN | ~drive_val);     // [R12] [R15] [R18]
    next_pu   = HAS_PULLUP & pu_sel_in & ~port_off_in
                & ~(next_oe & ~next_pad);                              // [R16] [R17] [R19]
    next_level = gated;
    // Latch shows for plain outputs and for every RMW read, except on a pin that port_off_in turns off
    if ((rmw_in || (dir_in && !periph_oe_in)) && !port_off_in) begin   // [R6] [R8] [R21]
      rd_val_out = latch_in;                                           // [R4]
    end else begin
      rd_val_out = gated;                                              // [R5] [R9]
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pad_out    <= 1'b0;
      pad_oe_out <= 1'b0;
      pullup_out <= 1'b0;
      level_out  <= 1'b0;
    end else begin
      pad_out    <= next_pad;
      pad_oe_out <= next_oe;
      pullup_out <= next_pu;
      level_out  <= next_level;
    end
  end

endmodule

// ### hdl/gdp_dual_port.sv
/*
  Dual GPIO port: an 8-pin port with pull-ups and two open-drain pins,
  and a 3-pin port whose pin 2 may become the external reset input.
  Assumes a simple register port with read data one cycle after the
  read strobe, and pads sampled synchronously to clk_in.
*/
`timescale 1ns/100ps
module gdp_dual_port (
  // Clock and reset
  input  wire logic                         clk_in,
  input  wire logic                         rst_in,
  // Register port
  input  wire logic [gdp_pkg::ADDR_W-1:0]   addr_in,
  input  wire logic [gdp_pkg::DATA_W-1:0]   wdata_in,
  input  wire logic                         wr_in,
  input  wire logic                         rd_in,
  input  wire logic                         rmw_in,
  output logic      [gdp_pkg::DATA_W-1:0]   rdata_out,
  // Standby state of the device
  input  wire logic                         standby_in,
  // 8-pin port pads
  input  wire logic [gdp_pkg::P7_W-1:0]     p7_pad_in,
  output logic      [gdp_pkg::P7_W-1:0]     p7_pad_out,
  output logic      [gdp_pkg::P7_W-1:0]     p7_pad_oe_out,
  output logic      [gdp_pkg::P7_W-1:0]     p7_pullup_out,
  // 8-pin port peripheral side
  input  wire logic [gdp_pkg::P7_W-1:0]     p7_periph_oe_in,
  input  wire logic [gdp_pkg::P7_W-1:0]     p7_periph_out_in,
  output logic      [gdp_pkg::P7_W-1:0]     p7_level_out,
  // 3-pin port pads
  input  wire logic [gdp_pkg::PF_W-1:0]     pf_pad_in,
  output logic      [gdp_pkg::PF_W-1:0]     pf_pad_out,
  output logic      [gdp_pkg::PF_W-1:0]     pf_pad_oe_out,
  // 3-pin port peripheral side
  input  wire logic [gdp_pkg::PF_W-1:0]     pf_periph_oe_in,
  input  wire logic [gdp_pkg::PF_W-1:0]     pf_periph_out_in,
  output logic      [gdp_pkg::PF_W-1:0]     pf_level_out,
  // External reset taken from the 3-pin port
  output logic                              ext_reset_out
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [gdp_pkg::P7_W-1:0]   port7_data_latch;
  logic [gdp_pkg::P7_W-1:0]   port7_direction;
  logic [gdp_pkg::P7_W-1:0]   port7_pullup_select;
  logic [gdp_pkg::PF_W-1:0]   portf_data_latch;
  logic [gdp_pkg::PF_W-1:0]   portf_direction;
  logic [gdp_pkg::CTRL_W-1:0] ctrl;

  logic [gdp_pkg::P7_W-1:0]   next_port7_data_latch;
  logic [gdp_pkg::P7_W-1:0]   next_port7_direction;
  logic [gdp_pkg::P7_W-1:0]   next_port7_pullup_select;
  logic [gdp_pkg::PF_W-1:0]   next_portf_data_latch;
  logic [gdp_pkg::PF_W-1:0]   next_portf_direction;
  logic [gdp_pkg::CTRL_W-1:0] next_ctrl;

  // ----------------------------------------------------------------
  // Derived controls
  // ----------------------------------------------------------------
  logic                       standby_pin_float;
  logic                       ext_reset_pin_select;
  logic                       floated;
  logic [gdp_pkg::P7_W-1:0]   p7_wake;
  logic [gdp_pkg::PF_W-1:0]   pf_off;

  // Read path
  logic [gdp_pkg::P7_W-1:0]   p7_rd;
  logic [gdp_pkg::PF_W-1:0]   pf_rd;
  logic [gdp_pkg::DATA_W-1:0] next_rdata;

  // Reset pin output
  logic                       next_ext_reset;

  // ----------------------------------------------------------------
  // Control decode
  // ----------------------------------------------------------------
  always_comb begin
    standby_pin_float    = ctrl[gdp_pkg::CTRL_FLOAT];
    ext_reset_pin_select = ctrl[gdp_pkg::CTRL_RST_SEL];
    // Float only bites in stop or watch mode with the bit set
    floated = standby_in & standby_pin_float;                          // [R12] [R15]
    p7_wake = '0;
    p7_wake[gdp_pkg::P7_CNT_PIN] = ctrl[gdp_pkg::CTRL_WAKE_CNT];
    p7_wake[gdp_pkg::P7_SCK_PIN] = ctrl[gdp_pkg::CTRL_WAKE_SCK];
    p7_wake[gdp_pkg::P7_SDI_PIN] = ctrl[gdp_pkg::CTRL_WAKE_SDI];
    p7_wake = p7_wake & gdp_pkg::P7_WAKE_MASK;                         // [R14]
    pf_off = '0;
    pf_off[gdp_pkg::PF_RST_PIN] = ext_reset_pin_select;                // [R21]
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_comb begin
    next_port7_data_latch    = port7_data_latch;
    next_port7_direction     = port7_direction;
    next_port7_pullup_select = port7_pullup_select;
    next_portf_data_latch    = portf_data_latch;
    next_portf_direction     = portf_direction;
    next_ctrl                = ctrl;
    if (wr_in) begin
      unique case (addr_in)
        gdp_pkg::OFS_P7_DATA: begin
          // Latch takes the value even on input pins
          next_port7_data_latch = wdata_in;                            // [R3] [R19]
        end
        gdp_pkg::OFS_P7_DIR: begin
          next_port7_direction = wdata_in;                             // [R1]
        end
        gdp_pkg::OFS_P7_PU: begin
          // Open-drain pins have no pull-up bit
          next_port7_pullup_select = wdata_in & gdp_pkg::P7_PU_MASK;   // [R16] [R19] [R22]
        end
        gdp_pkg::OFS_PF_DATA: begin
          next_portf_data_latch = wdata_in[gdp_pkg::PF_W-1:0];         // [R3] [R20] [R22]
        end
        gdp_pkg::OFS_PF_DIR: begin
          next_portf_direction = wdata_in[gdp_pkg::PF_W-1:0];          // [R1] [R20] [R22]
        end
        gdp_pkg::OFS_CTRL: begin
          next_ctrl = wdata_in[gdp_pkg::CTRL_W-1:0];
        end
        default: begin
          // Status and unmapped offsets ignore writes
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      port7_data_latch    <= gdp_pkg::P7_DATA_RST;
      port7_direction     <= gdp_pkg::P7_DIR_RST;                      // [R11]
      port7_pullup_select <= gdp_pkg::P7_PU_RST;
      portf_data_latch    <= gdp_pkg::PF_DATA_RST;
      portf_direction     <= gdp_pkg::PF_DIR_RST;                      // [R11]
      ctrl                <= gdp_pkg::CTRL_RST;
    end else begin
      port7_data_latch    <= next_port7_data_latch;
      port7_direction     <= next_port7_direction;
      port7_pullup_select <= next_port7_pullup_select;
      portf_data_latch    <= next_portf_data_latch;
      portf_direction     <= next_portf_direction;
      ctrl                <= next_ctrl;
    end
  end

  // ----------------------------------------------------------------
  // 8-pin port cells
  // ----------------------------------------------------------------
  // Peripheral enables are used as given; keeping them off on plain
  // port pins is up to software [R10]
  generate
    for (genvar i = 0; i < gdp_pkg::P7_W; i++) begin : g_p7
      gdp_pin_cell #(
        .OPEN_DRAIN (gdp_pkg::P7_OD_MASK[i]),                          // [R18]
        .HAS_PULLUP (gdp_pkg::P7_PU_MASK[i])                           // [R19]
      ) u_cell (
        .clk_in        (clk_in),
        .rst_in        (rst_in),
        .dir_in        (port7_direction[i]),
        .latch_in      (port7_data_latch[i]),
        .pu_sel_in     (port7_pullup_select[i]),
        .rmw_in        (rmw_in),
        .periph_oe_in  (p7_periph_oe_in[i]),
        .periph_out_in (p7_periph_out_in[i]),
        .float_in      (floated),
        .wake_en_in    (p7_wake[i]),
        .port_off_in   (1'b0),
        .pad_in        (p7_pad_in[i]),
        .pad_out       (p7_pad_out[i]),
        .pad_oe_out    (p7_pad_oe_out[i]),
        .pullup_out    (p7_pullup_out[i]),
        .level_out     (p7_level_out[i]),
        .rd_val_out    (p7_rd[i])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // 3-pin port cells
  // ----------------------------------------------------------------
  generate
    for (genvar j = 0; j < gdp_pkg::PF_W; j++) begin : g_pf
      gdp_pin_cell #(
        .OPEN_DRAIN (1'b0),
        .HAS_PULLUP (1'b0)                                             // [R20]
      ) u_cell (
        .clk_in        (clk_in),
        .rst_in        (rst_in),
        .dir_in        (portf_direction[j]),
        .latch_in      (portf_data_latch[j]),
        .pu_sel_in     (1'b0),
        .rmw_in        (rmw_in),
        .periph_oe_in  (pf_periph_oe_in[j]),
        .periph_out_in (pf_periph_out_in[j]),
        .float_in      (floated),
        .wake_en_in    (1'b0),
        .port_off_in   (pf_off[j]),                                    // [R21]
        .pad_in        (pf_pad_in[j]),
        .pad_out       (pf_pad_out[j]),
        .pad_oe_out    (pf_pad_oe_out[j]),
        .pullup_out    (),
        .level_out     (pf_level_out[j]),
        .rd_val_out    (pf_rd[j])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = gdp_pkg::RDATA_RST;
    if (rd_in) begin
      unique case (addr_in)
        gdp_pkg::OFS_P7_DATA: begin
          next_rdata = p7_rd;                                          // [R4] [R5] [R6]
        end
        gdp_pkg::OFS_P7_DIR: begin
          next_rdata = port7_direction;
        end
        gdp_pkg::OFS_P7_PU: begin
          next_rdata = port7_pullup_select;                            // [R22]
        end
        gdp_pkg::OFS_PF_DATA: begin
          next_rdata[gdp_pkg::PF_W-1:0] = pf_rd;                       // [R20] [R22]
        end
        gdp_pkg::OFS_PF_DIR: begin
          next_rdata[gdp_pkg::PF_W-1:0] = portf_direction;             // [R22]
        end
        gdp_pkg::OFS_CTRL: begin
          next_rdata[gdp_pkg::CTRL_W-1:0] = ctrl;
        end
        gdp_pkg::OFS_STATUS: begin
          next_rdata[gdp_pkg::STAT_FLOATED] = floated;
          next_rdata[gdp_pkg::STAT_STANDBY] = standby_in;
          next_rdata[gdp_pkg::STAT_RST_PIN] = ext_reset_pin_select;
        end
        default: begin
          // Unmapped offsets read as zero
          next_rdata = gdp_pkg::RDATA_RST;
        end
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= gdp_pkg::RDATA_RST;
    end else begin
      rdata_out <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // External reset pin
  // ----------------------------------------------------------------
  // Reset input is never floated or blocked, even in standby
  always_comb begin
    next_ext_reset = ext_reset_pin_select & pf_pad_in[gdp_pkg::PF_RST_PIN];  // [R21]
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ext_reset_out <= 1'b0;
    end else begin
      ext_reset_out <= next_ext_reset;
    end
  end

endmodule

// ### tb/gdp_board_model.sv
/*
  Board model: resolves each pad from device drive, external driver
  and pull-up.
  Assumes one clock domain.
*/
`timescale 1ns/100ps
module gdp_board_model #(
  parameter int W = 8
) (
  // Clock
  input  wire logic         clk_in,
  // Device side
  input  wire logic [W-1:0] dev_out_in,
  input  wire logic [W-1:0] dev_oe_in,
  input  wire logic [W-1:0] pullup_in,
  // External driver
  input  wire logic [W-1:0] ext_oe_in,
  input  wire logic [W-1:0] ext_val_in,
  // Resolved pad
  output logic      [W-1:0] pad_out
);
  // ----------------------------------------------------------------
  // Pad resolution
  // ----------------------------------------------------------------
  logic [W-1:0] last_q = '0;
  always_ff @(posedge clk_in) begin
    last_q <= pad_out;
  end
  // Open pad wanders each cycle, so a stale level is never trusted
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (dev_oe_in[i] && ext_oe_in[i]) begin
        pad_out[i] = 1'bx;
      end else if (dev_oe_in[i]) begin
        pad_out[i] = dev_out_in[i];
      end else if (ext_oe_in[i]) begin
        pad_out[i] = ext_val_in[i];
      end else begin
        pad_out[i] = pullup_in[i] | ~last_q[i];
      end
    end
  end
endmodule

// ### tb/gdp_port_monitor.sv
/*
  Checker for the dual GPIO port, bound to every gdp_dual_port.
  Assumes it sees only the top module's ports.
*/
`timescale 1ns/100ps
module gdp_port_monitor (
  // Clock and reset
  input wire logic       clk_in,
  input wire logic       rst_in,
  // Register port
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic       standby_in,
  // Port pads and peripherals
  input wire logic [7:0] p7_pad_in,
  input wire logic [7:0] p7_pad_out,
  input wire logic [7:0] p7_pad_oe_out,
  input wire logic [7:0] p7_pullup_out,
  input wire logic [7:0] p7_periph_oe_in,
  input wire logic [7:0] p7_periph_out_in,
  input wire logic [7:0] p7_level_out,
  input wire logic [2:0] pf_pad_in,
  input wire logic [2:0] pf_pad_oe_out,
  input wire logic [2:0] pf_level_out,
  input wire logic       ext_reset_out
);
  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic [7:0] drv_q;
  logic [7:0] val_q;
  logic [7:0] next_drv;
  logic [7:0] next_val;
  // Standby may float the pins, so only awake overrides are tracked
  always_comb begin
    next_drv = standby_in ? 8'h00 : (p7_periph_oe_in & gdp_pkg::P7_PU_MASK);
    next_val = p7_periph_out_in;
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      drv_q <= 8'h00;
      val_q <= 8'h00;
    end else begin
      drv_q <= next_drv;
      val_q <= next_val;
    end
  end
  sequence s_awake;
    !standby_in;
  endsequence
  sequence s_slept;
    $past(standby_in);
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_rdata_quiet: assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("rdata slot");
  chk_od_never_high: assert property (p7_pad_out[3:2] == 2'b00)
    else $error("od high");
  chk_pu_od_absent: assert property (p7_pullup_out[3:2] == 2'b00)
    else $error("od pull-up");
  chk_pu_low_off: assert property ((p7_pullup_out & p7_pad_oe_out & ~p7_pad_out) == 8'h00)
    else $error("pull-up low");
  chk_periph_drive: assert property (((p7_pad_oe_out & drv_q) == drv_q)
    && (((p7_pad_out ^ val_q) & drv_q) == 8'h00))
    else $error("periph drive");
  chk_level_pass: assert property (s_awake |=> p7_level_out == $past(p7_pad_in))
    else $error("level path");
  chk_stby_kept: assert property (s_slept and (|p7_pad_oe_out)
    |-> p7_level_out == $past(p7_pad_in))
    else $error("standby path");
  chk_float_gate: assert property (s_slept and (|(p7_level_out & ~gdp_pkg::P7_WAKE_MASK))
    |-> p7_level_out == $past(p7_pad_in))
    else $error("float gate");
  chk_rst_pin_off: assert property (ext_reset_out |-> !pf_pad_oe_out[2] && !pf_level_out[2])
    else $error("reset pin port");
  chk_rst_copy: assert property (ext_reset_out |-> $past(pf_pad_in[2]))
    else $error("reset copy");
endmodule

bind gdp_dual_port gdp_port_monitor u_mon (.*);

// ### tb/gdp_dual_port_test.sv
/*
  Self-checking bench for the dual GPIO port with board models.
  Assumes the design's register port timing.
*/
`timescale 1ns/100ps
module gdp_dual_port_test;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic       clk_in = 1'b0;
  logic       rst_in = 1'b1;
  logic [2:0] addr_in = 3'h0;
  logic [7:0] wdata_in = 8'h00;
  logic       wr_in = 1'b0;
  logic       rd_in = 1'b0;
  logic       rmw_in = 1'b0;
  logic       standby_in = 1'b0;
  logic [7:0] p7_periph_oe_in = 8'h00;
  logic [7:0] p7_periph_out_in = 8'h00;
  logic [7:0] p7_eoe = 8'h00;
  logic [7:0] p7_eval = 8'h00;
  logic [2:0] pf_periph_oe_in = 3'h0;
  logic [2:0] pf_periph_out_in = 3'h0;
  logic [2:0] pf_eoe = 3'h0;
  logic [2:0] pf_eval = 3'h0;
  logic [7:0] p7_pad_in, p7_pad_out, p7_pad_oe_out, p7_pullup_out, p7_level_out;
  logic [2:0] pf_pad_in, pf_pad_out, pf_pad_oe_out, pf_level_out;
  logic [7:0] rdata_out;
  logic [7:0] rd_v;
  logic       ext_reset_out;
  int         fail_count = 0;
  int         check_count = 0;
  gdp_dual_port dut (.*);
  gdp_board_model #(.W(8)) u_b7 (.clk_in, .dev_out_in(p7_pad_out), .dev_oe_in(p7_pad_oe_out),
    .pullup_in(p7_pullup_out), .ext_oe_in(p7_eoe), .ext_val_in(p7_eval), .pad_out(p7_pad_in));
  gdp_board_model #(.W(3)) u_bf (.clk_in, .dev_out_in(pf_pad_out), .dev_oe_in(pf_pad_oe_out),
    .pullup_in(3'h0), .ext_oe_in(pf_eoe), .ext_val_in(pf_eval), .pad_out(pf_pad_in));
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic m);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    rmw_in <= m;
    @(posedge clk_in);
    rd_in <= 1'b0;
    rmw_in <= 1'b0;
    #1 rd_v = rdata_out;
  endtask
  // Pins lag their cause by one stage
  task automatic settle;
    repeat (2) @(posedge clk_in);
    #1;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    wr(gdp_pkg::OFS_P7_DIR, 8'hFF);
    wr(gdp_pkg::OFS_PF_DIR, 8'hFF);
    settle;
    check(p7_pad_oe_out, 8'hFF);
    check({5'h00, pf_pad_oe_out}, 8'h07);
    rst_in <= 1'b1;
    @(posedge clk_in);
    rst_in <= 1'b0;
    #1 check(p7_pad_oe_out, 8'h00);
    rd(gdp_pkg::OFS_P7_DIR, 1'b0);
    check(rd_v, 8'h00);
    rd(gdp_pkg::OFS_PF_DIR, 1'b0);
    check(rd_v, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_output;
    wr(gdp_pkg::OFS_P7_DATA, 8'h5A);
    wr(gdp_pkg::OFS_P7_DIR, 8'hFF);
    settle;
    check(p7_pad_oe_out, 8'hF7);
    check(p7_pad_out & 8'hF3, 8'h52);
    rd(gdp_pkg::OFS_P7_DATA, 1'b0);
    check(rd_v, 8'h5A);
    $display("test output done");
  endtask
  task automatic t_pullup;
    wr(gdp_pkg::OFS_P7_PU, 8'hFF);
    rd(gdp_pkg::OFS_P7_PU, 1'b0);
    check(rd_v, 8'hF3);
    wr(gdp_pkg::OFS_P7_DATA, 8'hF0);
    settle;
    check(p7_pullup_out, 8'hF0);
    wr(gdp_pkg::OFS_P7_DIR, 8'h00);
    settle;
    check(p7_pullup_out, 8'hF3);
    $display("test pullup done");
  endtask
  task automatic t_input;
    wr(gdp_pkg::OFS_P7_DATA, 8'h3C);
    wr(gdp_pkg::OFS_PF_DATA, 8'hFD);
    p7_eoe <= 8'hFF;
    p7_eval <= 8'hC3;
    pf_eoe <= 3'h7;
    pf_eval <= 3'h2;
    settle;
    check(p7_pad_oe_out, 8'h00);
    rd(gdp_pkg::OFS_P7_DATA, 1'b0);
    check(rd_v, 8'hC3);
    rd(gdp_pkg::OFS_P7_DATA, 1'b1);
    check(rd_v, 8'h3C);
    rd(gdp_pkg::OFS_PF_DATA, 1'b0);
    check(rd_v, 8'h02);
    rd(gdp_pkg::OFS_PF_DATA, 1'b1);
    check(rd_v, 8'h05);
    $display("test input done");
  endtask
  task automatic t_periph;
    p7_eoe <= 8'hBE;
    p7_periph_oe_in <= 8'h41;
    p7_periph_out_in <= 8'h41;
    settle;
    check(p7_pad_oe_out, 8'h41);
    rd(gdp_pkg::OFS_P7_DATA, 1'b0);
    check(rd_v, 8'hC3);
    rd(gdp_pkg::OFS_P7_DATA, 1'b1);
    check(rd_v, 8'h3C);
    p7_periph_oe_in <= 8'h00;
    p7_eoe <= 8'h00;
    $display("test periph done");
  endtask
  task automatic t_stby;
    logic [7:0] wk [3] = '{8'h10, 8'h20, 8'h80};
    wr(gdp_pkg::OFS_P7_DATA, 8'h81);
    wr(gdp_pkg::OFS_P7_DIR, 8'hFF);
    standby_in <= 1'b1;
    settle;
    check(p7_pad_oe_out, 8'hFF);
    check(p7_pad_out, 8'h81);
    wr(gdp_pkg::OFS_CTRL, 8'h01);
    settle;
    check(p7_pad_oe_out, 8'h00);
    p7_eoe <= 8'hFF;
    p7_eval <= 8'hFF;
    settle;
    check(p7_level_out, 8'h00);
    rd(gdp_pkg::OFS_STATUS, 1'b0);
    check(rd_v, 8'h03);
    for (int i = 0; i < 3; i++) begin
      wr(gdp_pkg::OFS_CTRL, 8'h01 | (8'h04 << i));
      settle;
      check(p7_level_out, wk[i]);
    end
    p7_eoe <= 8'h00;
    standby_in <= 1'b0;
    wr(gdp_pkg::OFS_CTRL, 8'h00);
    $display("test standby done");
  endtask
  task automatic t_rstpin;
    wr(gdp_pkg::OFS_CTRL, 8'h02);
    wr(gdp_pkg::OFS_PF_DATA, 8'h07);
    wr(gdp_pkg::OFS_PF_DIR, 8'h07);
    pf_eoe <= 3'h4;
    pf_eval <= 3'h4;
    settle;
    check({5'h00, pf_pad_oe_out}, 8'h03);
    check({5'h00, pf_pad_out & 3'h3}, 8'h03);
    check({7'h00, ext_reset_out}, 8'h01);
    rd(gdp_pkg::OFS_PF_DATA, 1'b0);
    check(rd_v, 8'h03);
    wr(3'h7, 8'hFF);
    wr(gdp_pkg::OFS_STATUS, 8'h00);
    rd(3'h7, 1'b0);
    check(rd_v, 8'h00);
    rd(gdp_pkg::OFS_STATUS, 1'b0);
    check(rd_v, 8'h04);
    $display("test reset pin done");
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset;
    t_output;
    t_pullup;
    t_input;
    t_periph;
    t_stby;
    t_rstpin;
    stop_test;
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    fail_count++;
    stop_test;
  end
endmodule
